// >>> rtl/ipp_defs.svh
// constants for the interrupt priority and pending block
// Summary of operation
// - masked levels never reach the processor
// - groups: A=0-1, B=2-4, C=5-7
// - three-bit code selects group order
// - eight read-only pending flags, zero at reset
// - two byte registers form 16-bit pointer
`ifndef IPP_DEFS_SVH
`define IPP_DEFS_SVH
`define IPP_OFS_PTR_HIGH 8'hda
`define IPP_OFS_PTR_LOW 8'hdb
`define IPP_OFS_PENDING 8'hdc
`define IPP_OFS_MASK 8'hdd
`define IPP_OFS_IRQ_STAT 8'he0
`define IPP_OFS_IRQ_CLR 8'he1
`define IPP_OFS_IRQ_EN 8'he2
`define IPP_OFS_GROUP_CFG 8'hff
`define IPP_CFG_CODE_LO 1
`define IPP_CFG_CODE_MID 4
`define IPP_CFG_CODE_HI 7
`define IPP_PENDING_RST 8'h00
`define IPP_MASK_RST 8'h00
`define IPP_CFG_RST 8'h00
`define IPP_PTR_RST 8'h00
`define IPP_EV_GRANT 0
`define IPP_EV_UNDEF 1
`endif

// >>> rtl/ipp_pkg.sv
// types for the interrupt priority and pending block
package ipp_pkg;
  typedef enum logic [1:0]
  {
    IPP_GRP_A = 2'h0,
    IPP_GRP_B = 2'h1,
    IPP_GRP_C = 2'h2,
    IPP_GRP_NONE = 2'h3
  } ipp_group_type;

  typedef enum logic [1:0]
  {
    IPP_IDLE = 2'h0,
    IPP_OFFER = 2'h1
  } ipp_state_type;

  typedef struct packed
  {
    ipp_state_type state;
    logic [7:0] pending;
    logic [7:0] mask;
    logic [7:0] cfg;
    logic [7:0] ptr_high;
    logic [7:0] ptr_low;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [7:0] rdata;
    logic req_valid;
    logic [2:0] req_level;
  } ipp_top_type;
endpackage : ipp_pkg

// >>> rtl/ipp_sel_if.sv
// carrier between the top and the priority resolver
`timescale 1ns/1ps
interface ipp_sel_if;
  logic [7:0] active;
  logic [2:0] code;
  logic found;
  logic [2:0] level;
  logic undefined;
  modport top (output active, output code, input found, input level, input undefined);
  modport sel (input active, input code, output found, output level, output undefined);
endinterface : ipp_sel_if

// >>> rtl/ipp_resolve.sv
// combinational group priority resolver
`timescale 1ns/1ps
module ipp_resolve
  import ipp_pkg::*;
(
  // request side
  ipp_sel_if.sel sel
);
  // lowest active level of a group; inside a group lower number first
  function automatic logic [3:0] ipp_pick(input logic [7:0] act, input ipp_group_type g);
    logic [3:0] r;
    r = 4'h0;
    case (g)
      IPP_GRP_A: r = act[0] ? 4'h8 : act[1] ? 4'h9 : 4'h0;
      IPP_GRP_B: r = act[2] ? 4'ha : act[3] ? 4'hb : act[4] ? 4'hc : 4'h0;
      IPP_GRP_C: r = act[5] ? 4'hd : act[6] ? 4'he : act[7] ? 4'hf : 4'h0;
      default: r = 4'h0;
    endcase
    return r;
  endfunction : ipp_pick

  ipp_group_type ord [3];
  logic [3:0] p0, p1, p2;

  always_comb
  begin
    // group order from the code
    ord[0] = IPP_GRP_A;
    ord[1] = IPP_GRP_B;
    ord[2] = IPP_GRP_C;
    sel.undefined = 1'b0;
    case (sel.code)
      3'h1: begin ord[0] = IPP_GRP_B; ord[1] = IPP_GRP_C; ord[2] = IPP_GRP_A; end
      3'h2: begin ord[0] = IPP_GRP_A; ord[1] = IPP_GRP_B; ord[2] = IPP_GRP_C; end
      3'h3: begin ord[0] = IPP_GRP_B; ord[1] = IPP_GRP_A; ord[2] = IPP_GRP_C; end
      3'h4: begin ord[0] = IPP_GRP_C; ord[1] = IPP_GRP_A; ord[2] = IPP_GRP_B; end
      3'h5: begin ord[0] = IPP_GRP_C; ord[1] = IPP_GRP_B; ord[2] = IPP_GRP_A; end
      3'h6: begin ord[0] = IPP_GRP_A; ord[1] = IPP_GRP_C; ord[2] = IPP_GRP_B; end
      default: sel.undefined = 1'b1;
    endcase
    p0 = ipp_pick(sel.active, ord[0]);
    p1 = ipp_pick(sel.active, ord[1]);
    p2 = ipp_pick(sel.active, ord[2]);
    // first group in order with an active level wins
    if (p0[3])
      sel.level = p0[2:0];
    else if (p1[3])
      sel.level = p1[2:0];
    else
      sel.level = p2[2:0];
    sel.found = p0[3] | p1[3] | p2[3];
  end
endmodule : ipp_resolve

// >>> rtl/ipp_top.sv
// interrupt pending flags, masking, group priority and pointer registers
`timescale 1ns/1ps
`include "ipp_defs.svh"
module ipp_top
  import ipp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // level sources and processor side
  input wire logic [7:0] src_req,
  input wire logic [7:0] src_done,
  output logic cpu_req,
  output logic [2:0] cpu_level,
  input wire logic cpu_ack,
  output logic [15:0] instr_ptr,
  // interrupt
  output logic irq
);
  ipp_top_type q, d;
  ipp_sel_if sel_c ();

  ipp_resolve u_resolve
  (
    .sel(sel_c.sel)
  );

  // ************************************************************
  // priority request path
  // ************************************************************
  assign sel_c.active = q.pending & q.mask;
  assign sel_c.code = {q.cfg[`IPP_CFG_CODE_HI], q.cfg[`IPP_CFG_CODE_MID],
    q.cfg[`IPP_CFG_CODE_LO]};

  always_comb
  begin
    logic [7:0] clr;
    logic [1:0] ev;
    clr = 8'h00;
    ev = 2'h0;
    d = q;
    d.rdata = 8'h00;
    // flags set by sources; a set beats a clear in the same cycle
    d.pending = (q.pending & ~src_done) | src_req;
    case (q.state)
      IPP_IDLE:
      begin
        if (sel_c.found)
        begin
          d.state = IPP_OFFER;
          d.req_valid = 1'b1;
          d.req_level = sel_c.level;
        end
      end
      IPP_OFFER:
      begin
        // withdraw if the level got masked or dropped
        if (cpu_ack || !sel_c.active[q.req_level])
        begin
          d.state = IPP_IDLE;
          d.req_valid = 1'b0;
          ev[`IPP_EV_GRANT] = cpu_ack;
        end
        else if (sel_c.level != q.req_level)
          d.req_level = sel_c.level;
      end
      default:
      begin
        d.state = IPP_IDLE;
        d.req_valid = 1'b0;
      end
    endcase
    ev[`IPP_EV_UNDEF] = sel_c.undefined && sel_c.found;
    // ************************************************************
    // register access
    // ************************************************************
    if (wr)
    begin
      case (addr)
        `IPP_OFS_PTR_HIGH: d.ptr_high = wdata;
        `IPP_OFS_PTR_LOW: d.ptr_low = wdata;
        `IPP_OFS_MASK: d.mask = wdata;
        `IPP_OFS_GROUP_CFG: d.cfg = wdata;
        `IPP_OFS_IRQ_CLR: clr = wdata;
        `IPP_OFS_IRQ_EN: d.irq_en = wdata[1:0];
        default: d.mask = q.mask;
      endcase
    end
    if (rd)
    begin
      case (addr)
        `IPP_OFS_PTR_HIGH: d.rdata = q.ptr_high;
        `IPP_OFS_PTR_LOW: d.rdata = q.ptr_low;
        `IPP_OFS_PENDING: d.rdata = q.pending;
        `IPP_OFS_MASK: d.rdata = q.mask;
        `IPP_OFS_GROUP_CFG: d.rdata = q.cfg;
        `IPP_OFS_IRQ_STAT: d.rdata = {6'h00, q.irq_stat};
        `IPP_OFS_IRQ_EN: d.rdata = {6'h00, q.irq_en};
        default: d.rdata = 8'h00;
      endcase
    end
    d.irq_stat = (q.irq_stat & ~clr[1:0]) | ev;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      q.state <= IPP_IDLE;
      q.pending <= `IPP_PENDING_RST;
      q.mask <= `IPP_MASK_RST;
      q.cfg <= `IPP_CFG_RST;
      q.ptr_high <= `IPP_PTR_RST;
      q.ptr_low <= `IPP_PTR_RST;
      q.irq_stat <= 2'h0;
      q.irq_en <= 2'h0;
      q.rdata <= 8'h00;
      q.req_valid <= 1'b0;
      q.req_level <= 3'h0;
    end
    else
      q <= d;
  end

  assign rdata = q.rdata;
  assign cpu_req = q.req_valid & sel_c.active[q.req_level];
  assign cpu_level = q.req_level;
  assign instr_ptr = {q.ptr_high, q.ptr_low};
  assign irq = |(q.irq_stat & q.irq_en);

  // ************************************************************
  // checks
  // ************************************************************
  masked_no_req_a: assert property (@(posedge mclk) disable iff (!nrst)
    cpu_req |-> q.mask[cpu_level])
    else $error("request presented on a masked level");
  pend_reset_a: assert property (@(posedge mclk)
    !nrst |=> q.pending == 8'h00)
    else $error("pending flags not cleared by reset");
  pend_ro_a: assert property (@(posedge mclk) disable iff (!nrst)
    (wr && addr == `IPP_OFS_PENDING && src_req == 8'h00 && src_done == 8'h00)
    |=> q.pending == $past(q.pending))
    else $error("pending flags changed by a write");
  ptr_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    (wr && addr == `IPP_OFS_PTR_LOW) |=> instr_ptr[7:0] == $past(wdata))
    else $error("pointer low byte not written");
  ptr_read_a: assert property (@(posedge mclk) disable iff (!nrst)
    (rd && addr == `IPP_OFS_PTR_HIGH) |=> rdata == $past(q.ptr_high))
    else $error("pointer high byte misread");
  order_bca_a: assert property (@(posedge mclk) disable iff (!nrst)
    (sel_c.code == 3'h1 && sel_c.active[2] && sel_c.active[5]) |-> sel_c.level == 3'h2)
    else $error("group B not above group C");
  order_cab_a: assert property (@(posedge mclk) disable iff (!nrst)
    (sel_c.code == 3'h4 && sel_c.active[0] && sel_c.active[7]) |-> sel_c.level >= 3'h5)
    else $error("group C not above group A");
  group_a_a: assert property (@(posedge mclk) disable iff (!nrst)
    (sel_c.active == 8'h02) |-> sel_c.found && sel_c.level == 3'h1)
    else $error("level one not resolved");
  offer_next_a: assert property (@(posedge mclk) disable iff (!nrst)
    (q.state == IPP_IDLE && sel_c.found) |=> q.req_valid ##0 q.req_level == $past(sel_c.level))
    else $error("winning level not offered");
endmodule : ipp_top

// >>> test/ipp_cpu_model.sv
// cpu core model that accepts offered interrupt levels
`timescale 1ns/1ps
module ipp_cpu_model #(parameter int LAT = 2)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // offer from the block
  input wire logic cpu_req,
  input wire logic [2:0] cpu_level,
  input wire logic ack_en,
  // acceptance
  output logic cpu_ack
);
  int cnt;
  logic [2:0] lvl_q;
  // ack one cycle after LAT cycles of a steady offer
  always_ff @(posedge mclk)
  begin
    cpu_ack <= 1'b0;
    cnt <= 0;
    lvl_q <= cpu_level;
    if (nrst && cpu_req && ack_en && !cpu_ack && cpu_level == lvl_q)
    begin
      cnt <= cnt + 1;
      cpu_ack <= (cnt == LAT - 1);
    end
  end
endmodule : ipp_cpu_model

// >>> test/ipp_top_tb.sv
// self-checking bench for the interrupt priority and pending block
`timescale 1ns/1ps
module ipp_top_tb;
  import ipp_pkg::*;
  logic mclk = 0, nrst = 0, wr = 0, rd = 0, ack_en = 0, cpu_req, cpu_ack, irq;
  logic [7:0] addr = 0, wdata = 0, src_req = 0, src_done = 0, rdata, hi, lo, m, d;
  logic [2:0] cpu_level, c;
  logic [15:0] instr_ptr;
  logic [3:0] ord;
  logic [2:0] lvl [3] = '{3'h1, 3'h3, 3'h6};
  logic [7:0] gm [3] = '{8'h03, 8'h1c, 8'he0};
  logic [31:0] seed = 32'h81d8;
  int errors = 0, n_compared = 0;
  always #2.5 mclk = ~mclk;
  ipp_top dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_req(src_req), .src_done(src_done), .cpu_req(cpu_req),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .instr_ptr(instr_ptr), .irq(irq));
  ipp_cpu_model #(.LAT(3)) partner (.mclk(mclk), .nrst(nrst), .cpu_req(cpu_req),
    .cpu_level(cpu_level), .ack_en(ack_en), .cpu_ack(cpu_ack));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // {first, second} group index for a group order code
  function automatic logic [3:0] order(input logic [2:0] k);
    case (k)
      3'h1: return 4'h6;
      3'h2: return 4'h1;
      3'h3: return 4'h4;
      3'h4: return 4'h8;
      3'h5: return 4'h9;
      default: return 4'h2;
    endcase
  endfunction : order
  task automatic close_out;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic src(input logic [7:0] s, input logic [7:0] k);
    @(posedge mclk);
    src_req <= s;
    src_done <= k;
    @(posedge mclk);
    src_req <= 8'h00;
    src_done <= 8'h00;
  endtask : src
  task automatic wait_req;
    #1;
    for (int i = 0; i < 20 && cpu_req !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    if (cpu_req !== 1'b1)
    begin
      errors++;
      close_out();
    end
  endtask : wait_req
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rreg(8'hdc, d);
    chk(16'(d), 16'h0000);
    wreg(8'hdc, 8'hff);
    rreg(8'hdc, d);
    chk(16'(d), 16'h0000);
    rreg(8'h10, d);
    chk(16'(d), 16'h0000);
    repeat (4)
    begin
      seed = lfsr(seed);
      hi = seed[7:0];
      lo = seed[15:8];
      wreg(8'hda, hi);
      wreg(8'hdb, lo);
      rreg(8'hda, d);
      chk(16'(d), 16'(hi));
      rreg(8'hdb, d);
      chk(instr_ptr, {hi, lo});
      chk(16'(d), 16'(lo));
    end
    repeat (4)
    begin
      seed = lfsr(seed);
      m = seed[7:0];
      wreg(8'hdd, m);
      src(~m, 8'h00);
      repeat (4)
      begin
        @(posedge mclk);
        #1 chk(16'(cpu_req), 16'h0000);
      end
      rreg(8'hdc, d);
      chk(16'(d), {8'h00, ~m});
      src(8'h00, 8'hff);
    end
    wreg(8'hdd, 8'hff);
    for (c = 3'h1; c != 3'h7; c++)
    begin
      ord = order(c);
      wreg(8'hff, {c[2], 2'h0, c[1], 2'h0, c[0], 1'b0});
      src(8'hda, 8'h00);
      wait_req();
      chk(16'(cpu_level), 16'(lvl[ord[3:2]]));
      src(8'h00, gm[ord[3:2]]);
      repeat (4) @(posedge mclk);
      wait_req();
      chk(16'(cpu_level), 16'(lvl[ord[1:0]]));
      src(8'h00, 8'hff);
      repeat (3) @(posedge mclk);
    end
    wreg(8'he2, 8'h01);
    ack_en <= 1'b1;
    src(8'h04, 8'h00);
    wait_req();
    repeat (6) @(posedge mclk);
    #1 chk(16'(irq), 16'h0001);
    rreg(8'he0, d);
    chk(16'(d[0]), 16'h0001);
    ack_en <= 1'b0;
    src(8'h00, 8'hff);
    wreg(8'he1, 8'h03);
    repeat (2) @(posedge mclk);
    #1 chk(16'(irq), 16'h0000);
    // undefined group code: level still offered, flagged in status bit 1
    wreg(8'hff, 8'h92);
    src(8'h20, 8'h00);
    wait_req();
    chk(16'(cpu_level), 16'h0005);
    rreg(8'he0, d);
    chk(16'(d), 16'h0002);
    src(8'h00, 8'hff);
    wreg(8'he1, 8'h03);
    close_out();
  end
endmodule : ipp_top_tb
